//--- logic/ipg_core.sv
// Interleaved two-phase gate control core: oscillator, phase toggle,
// clock latches, demag gating and protection blocking.
// Assumes all comparator inputs are digital and synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module ipg_core
  import ipg_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_CYC
)
(
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                osc_above_high,
  input  wire logic                osc_below_low,
  input  wire logic                demag_sense_1_high,
  input  wire logic                demag_sense_1_low,
  input  wire logic                demag_sense_2_high,
  input  wire logic                demag_sense_2_low,
  input  wire logic                inrush_cmp,
  input  wire logic                current_limit_cmp,
  input  wire logic                overvoltage,
  input  wire logic [ONTIME_W-1:0] ontime,
  output logic                     osc_discharge,
  output logic                     discharge_pulse,
  output logic                     phase_sel,
  output logic                     phase1_clock,
  output logic                     phase2_clock,
  output logic                     gate_drive_1,
  output logic                     gate_drive_2,
  output logic                     inrush_flag,
  output logic                     overcurrent_flag,
  output logic                     demag_latch_1,
  output logic                     demag_latch_2
);
  ipg_osc_e   osc_r;
  ipg_osc_e   osc_nxt;
  logic       sel_r;
  logic       sel_nxt;
  logic       disch_d_r;
  logic [1:0] clk_lat_r;
  logic [1:0] clk_lat_nxt;
  logic [1:0] clk_arm_r;
  logic [1:0] clk_arm_nxt;
  logic [1:0] drv_r;
  logic [1:0] drv_nxt;
  logic [1:0] demag_done;
  logic [1:0] demag_lat;
  logic [1:0] on_exp;
  logic [1:0] drv_start;
  logic       normal_seen_r;
  logic       normal_seen_nxt;
  logic       inrush_eff;
  logic       block;
  logic       pending;

  ipg_demag #(.WDOG_CYCLES(WDOG_CYCLES)) u_demag1
  (
    .clk         (clk),
    .nrst        (nrst),
    .sense_high  (demag_sense_1_high),
    .sense_low   (demag_sense_1_low),
    .drive       (drv_r[0]),
    .demag_latch (demag_lat[0]),
    .demag_done  (demag_done[0])
  );

  ipg_demag #(.WDOG_CYCLES(WDOG_CYCLES)) u_demag2
  (
    .clk         (clk),
    .nrst        (nrst),
    .sense_high  (demag_sense_2_high),
    .sense_low   (demag_sense_2_low),
    .drive       (drv_r[1]),
    .demag_latch (demag_lat[1]),
    .demag_done  (demag_done[1])
  );

  ipg_ontime u_on1
  (
    .clk         (clk),
    .nrst        (nrst),
    .start       (drv_start[0]),
    .overcurrent (overcurrent_flag),
    .ontime      (ontime),
    .expired     (on_exp[0])
  );

  ipg_ontime u_on2
  (
    .clk         (clk),
    .nrst        (nrst),
    .start       (drv_start[1]),
    .overcurrent (overcurrent_flag),
    .ontime      (ontime),
    .expired     (on_exp[1])
  );

  // Real drive or sensed demag masks in-rush
  // A watchdog-set latch must not count, or start-up in-rush would be masked
  assign normal_seen_nxt = normal_seen_r | (|drv_r) | demag_sense_1_high | demag_sense_2_high;
  assign inrush_eff      = inrush_cmp && !normal_seen_r;
  // In-rush and over-voltage block drives
  assign block   = inrush_eff || overvoltage;
  assign pending = |clk_lat_r;

  always_comb
  begin
    osc_nxt = osc_r;
    case (osc_r)
      IPG_OSC_CHARGE:
        if (osc_above_high)
          osc_nxt = IPG_OSC_DISCH;
      // Discharge stretched while a clock is pending
      IPG_OSC_DISCH:
        if (osc_below_low && !pending)
          osc_nxt = IPG_OSC_CHARGE;
      default:
        osc_nxt = IPG_OSC_CHARGE;
    endcase
  end

  always_comb
  begin
    sel_nxt     = sel_r;
    clk_arm_nxt = clk_arm_r;
    clk_lat_nxt = clk_lat_r;
    drv_nxt     = drv_r;
    // Discharge pulse arms the selected latch
    if (discharge_pulse && !disch_d_r)
      clk_arm_nxt[sel_r] = 1'b1;
    if (!discharge_pulse && disch_d_r)
    begin
      clk_lat_nxt = clk_lat_nxt | clk_arm_r;
      clk_arm_nxt = 2'b00;
      sel_nxt     = ~sel_r;
    end
    for (int i = 0; i < 2; i++)
    begin
      // Gate on with clock, demag done, no block
      if (clk_lat_r[i] && demag_done[i] && !block && !drv_r[i])
      begin
        drv_nxt[i]     = 1'b1;
        clk_lat_nxt[i] = 1'b0;
      end
      // On-time expiry, over-voltage or in-rush turns drive off
      else if (drv_r[i] && (on_exp[i] || block))
        drv_nxt[i] = 1'b0;
    end
  end

  assign discharge_pulse = (osc_r == IPG_OSC_DISCH);
  assign drv_start       = drv_nxt & ~drv_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_r         <= IPG_OSC_CHARGE;
      sel_r         <= 1'b0;
      disch_d_r     <= 1'b0;
      clk_arm_r     <= 2'b00;
      clk_lat_r     <= 2'b00;
      drv_r         <= 2'b00;
      normal_seen_r <= 1'b0;
    end
    else
    begin
      osc_r         <= osc_nxt;
      sel_r         <= sel_nxt;
      disch_d_r     <= discharge_pulse;
      clk_arm_r     <= clk_arm_nxt;
      clk_lat_r     <= clk_lat_nxt;
      drv_r         <= drv_nxt;
      normal_seen_r <= normal_seen_nxt;
    end
  end

  // One phase per oscillator cycle halves each gate rate
  assign phase_sel        = sel_r;
  assign osc_discharge    = discharge_pulse;
  assign phase1_clock     = clk_lat_r[0];
  assign phase2_clock     = clk_lat_r[1];
  assign gate_drive_1     = drv_r[0];
  assign gate_drive_2     = drv_r[1];
  assign inrush_flag      = inrush_eff;
  assign overcurrent_flag = current_limit_cmp;
  assign demag_latch_1    = demag_lat[0];
  assign demag_latch_2    = demag_lat[1];
endmodule : ipg_core
`default_nettype wire

//--- common/ipg_pkg.sv
// Constants shared by the interleaved phase gate control core.
// Assumes a single 25 MHz clock and comparator outputs already digital.
package ipg_pkg;
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  // Demag watchdog interval
  localparam int unsigned WDOG_US        = 200;
  localparam int unsigned WDOG_CYC       = (WDOG_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WDOG_W         = 14;
  // On-time count step per clock; doubled while current-limit flag is high
  localparam int unsigned ONTIME_W       = 12;
  localparam logic [11:0] ONTIME_DEF     = 12'h0fa;
  localparam logic [11:0] ONTIME_OC_STEP = 12'h001;
  localparam logic [11:0] ONTIME_MIN     = 12'h001;

  typedef enum logic [1:0]
  {
    IPG_OSC_CHARGE = 2'b01,
    IPG_OSC_DISCH  = 2'b10
  } ipg_osc_e;
endpackage : ipg_pkg

//--- logic/ipg_demag.sv
// Per-phase demagnetization latch with drive-low watchdog.
// Assumes comparator levels synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module ipg_demag
  import ipg_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_CYC
)
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic sense_high,
  input  wire logic sense_low,
  input  wire logic drive,
  output logic      demag_latch,
  output logic      demag_done
);
  logic             latch_r;
  logic             latch_nxt;
  logic             drive_d_r;
  logic [WDOG_W-1:0] wdog_r;
  logic [WDOG_W-1:0] wdog_nxt;
  logic             wdog_hit;

  assign wdog_hit = (wdog_r >= WDOG_W'(WDOG_CYCLES));

  always_comb
  begin
    wdog_nxt  = drive ? '0 : (wdog_hit ? wdog_r : wdog_r + WDOG_W'(1));
    latch_nxt = latch_r;
    if (drive && !drive_d_r)
      latch_nxt = 1'b0;
    if (sense_high || wdog_hit)
      latch_nxt = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      latch_r   <= 1'b0;
      drive_d_r <= 1'b0;
      wdog_r    <= '0;
    end
    else
    begin
      latch_r   <= latch_nxt;
      drive_d_r <= drive;
      wdog_r    <= wdog_nxt;
    end
  end

  assign demag_latch = latch_r;
  // Valid once input falls below lower threshold
  assign demag_done  = latch_r && sense_low;
endmodule : ipg_demag
`default_nettype wire

//--- logic/ipg_ontime.sv
// On-time counter for one phase; shortened while current limit is active.
// Assumes start is a one-cycle pulse at gate turn-on.
`timescale 1ns/10ps
`default_nettype none
module ipg_ontime
  import ipg_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                start,
  input  wire logic                overcurrent,
  input  wire logic [ONTIME_W-1:0] ontime,
  output logic                     expired
);
  logic [ONTIME_W-1:0] cnt_r;
  logic [ONTIME_W-1:0] cnt_nxt;
  logic [ONTIME_W-1:0] dec;

  assign dec = overcurrent ? (ONTIME_OC_STEP + ONTIME_OC_STEP) : ONTIME_OC_STEP;

  always_comb
  begin
    if (start)
      cnt_nxt = (ontime < ONTIME_MIN) ? ONTIME_MIN : ontime;
    else if (cnt_r > dec)
      cnt_nxt = cnt_r - dec;
    else
      cnt_nxt = '0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign expired = (cnt_r == '0) && !start;
endmodule : ipg_ontime
`default_nettype wire

//--- test/ipg_assertions.sv
// Port-level checks for the gate control core.
// Assumes it is bound onto ipg_core and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ipg_assertions
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic osc_above_high,
  input wire logic osc_below_low,
  input wire logic demag_sense_1_low,
  input wire logic inrush_cmp,
  input wire logic current_limit_cmp,
  input wire logic overvoltage,
  input wire logic osc_discharge,
  input wire logic discharge_pulse,
  input wire logic phase_sel,
  input wire logic phase1_clock,
  input wire logic phase2_clock,
  input wire logic gate_drive_1,
  input wire logic gate_drive_2,
  input wire logic inrush_flag,
  input wire logic overcurrent_flag,
  input wire logic demag_latch_1
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_osc_enter: assert property (osc_above_high && !osc_discharge |=> osc_discharge)
    else $error("discharge not entered");
  chk_osc_leave: assert property ($fell(osc_discharge) |-> $past(osc_below_low))
    else $error("discharge left early");
  chk_pulse_level: assert property (discharge_pulse == osc_discharge)
    else $error("pulse differs from discharge");
  chk_pulse_start: assert property ($rose(discharge_pulse) |-> $past(osc_above_high))
    else $error("pulse rose without upper threshold");
  chk_phase_one: assert property ($rose(phase1_clock) |-> phase_sel && !phase2_clock)
    else $error("phase 1 clock out of turn");
  chk_phase_two: assert property ($rose(phase2_clock) |-> !phase_sel && !phase1_clock)
    else $error("phase 2 clock out of turn");
  chk_clock_set: assert property ($fell(discharge_pulse) |=> phase1_clock != phase2_clock)
    else $error("no clock after pulse");
  chk_hold_disch: assert property (osc_discharge && (phase1_clock || phase2_clock)
    |=> osc_discharge || $rose(gate_drive_1) || $rose(gate_drive_2)) else $error("discharge not held");
  chk_block_off: assert property (inrush_flag || overvoltage |=> !gate_drive_1 && !gate_drive_2)
    else $error("gate on while blocked");
  chk_inrush_src: assert property (inrush_flag |-> inrush_cmp)
    else $error("in-rush flag without cause");
  chk_inrush_off: assert property (gate_drive_1 || gate_drive_2 |=> !inrush_flag)
    else $error("in-rush flag after switching");
  chk_oc_flag: assert property (overcurrent_flag == current_limit_cmp)
    else $error("over-current flag wrong");
  chk_gate_cause: assert property ($rose(gate_drive_1) |->
    $past(phase1_clock && demag_latch_1 && demag_sense_1_low && !overvoltage && !inrush_flag))
    else $error("gate 1 without cause");
endmodule : ipg_assertions
bind ipg_core ipg_assertions chk_u (.*);
`default_nettype wire

//--- test/ipg_winding.sv
// Boost inductor and auxiliary winding of one phase.
// Assumes drive is the gate output; sense levels change after clk edges.
`timescale 1ns/10ps
`default_nettype none
module ipg_winding
#(
  parameter int DEMAG = 6
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic drive,
  output logic     sense_high,
  output logic     sense_low
);
  int cnt_r;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) cnt_r <= 0;
    else if (drive) cnt_r <= DEMAG;
    else if (cnt_r != 0) cnt_r <= cnt_r - 1;
  assign sense_high = !drive && cnt_r != 0;
  assign sense_low  = !sense_high;
endmodule : ipg_winding
`default_nettype wire

//--- test/ipg_core_bench.sv
// Self-checking bench for the gate control core.
// Assumes ipg_core with a shortened watchdog and two winding models.
`timescale 1ns/10ps
`default_nettype none
module ipg_core_bench;
  import ipg_pkg::*;
  logic clk = 0, nrst = 0, inrush_cmp = 0, current_limit_cmp = 0, overvoltage = 0;
  logic osc_above_high, osc_below_low, demag_sense_1_high, demag_sense_1_low, demag_sense_2_high, demag_sense_2_low;
  logic [ONTIME_W-1:0] ontime = 12'h014;
  logic osc_discharge, discharge_pulse, phase_sel, phase1_clock, phase2_clock, gate_drive_1, gate_drive_2;
  logic inrush_flag, overcurrent_flag, demag_latch_1, demag_latch_2;
  int node = 4, cyc, miscompares, n_tests, g1, g2, last, alt_bad, w, n;
  ipg_core #(.WDOG_CYCLES(50)) dut_u (.*);
  ipg_winding #(.DEMAG(6)) w1_u (.clk, .nrst, .drive(gate_drive_1), .sense_high(demag_sense_1_high),
    .sense_low(demag_sense_1_low));
  ipg_winding #(.DEMAG(25)) w2_u (.clk, .nrst, .drive(gate_drive_2), .sense_high(demag_sense_2_high),
    .sense_low(demag_sense_2_low));
  initial forever #20 clk = !clk;
  // Timing node swings between the two thresholds
  always @(posedge clk) #1 node = osc_discharge ? node - 1 : node + 1;
  assign osc_above_high = node >= 8;
  assign osc_below_low  = node <= 2;
  always @(posedge gate_drive_1)
  begin
    if (last == 1) alt_bad++;
    last = 1;
    g1++;
  end
  always @(posedge gate_drive_2)
  begin
    if (last != 1) alt_bad++;
    last = 2;
    g2++;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic t_inrush();
    inrush_cmp = 1;
    tick(300);
    chk("gate count", 0, 16'(g1 + g2));
    chk("inrush_flag", 1, inrush_flag);
    inrush_cmp = 0;
  endtask : t_inrush
  task automatic t_alt();
    tick(600);
    chk("both phases", 1, (g1 > 2) && (g2 > 2));
    chk("alternation", 0, 16'(alt_bad));
    inrush_cmp = 1;
    n = g1 + g2;
    tick(200);
    chk("inrush_flag masked", 0, inrush_flag);
    chk("switching goes on", 1, g1 + g2 > n + 2);
    inrush_cmp = 0;
  endtask : t_alt
  task automatic t_width(input logic oc, input int exp);
    tick(1);
    current_limit_cmp = oc;
    @(posedge gate_drive_1);
    #1;
    w = 0;
    while (gate_drive_1 === 1'b1 && w < 100)
    begin
      tick(1);
      w++;
    end
    chk("overcurrent_flag", oc, overcurrent_flag);
    chk("gate width", 16'(exp), 16'(w));
    current_limit_cmp = 0;
  endtask : t_width
  task automatic t_ov();
    overvoltage = 1;
    tick(2);
    n = g1 + g2;
    tick(200);
    chk("gates during ov", 16'(n), 16'(g1 + g2));
    chk("gates low", 0, gate_drive_1 | gate_drive_2);
    overvoltage = 0;
    tick(300);
    chk("restart", 1, g1 + g2 > n);
  endtask : t_ov
  task automatic tally_and_finish();
    $display("counts: %0d compares, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial
  begin
    tick(10);
    nrst = 1;
    t_inrush();
    t_alt();
    // Gate stands from the load edge through the edge that sees the count at zero
    t_width(0, int'(ontime) + 1);
    t_width(1, int'(ontime) / 2 + 1);
    t_ov();
    tally_and_finish();
  end
endmodule : ipg_core_bench
`default_nettype wire
